/* File: logic/rcst_core.sv */
// reset-cause flags, start-up delays and sleep control for the core
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module rcst_core #(
    parameter int PWRT_CYCLES = rcst_pkg::PWRT_CYCLES,
    parameter int OST_CYCLES = rcst_pkg::OST_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // reset sources from pins and analog blocks
    input wire logic porReq,
    input wire logic brownReq,
    input wire logic external_reset_pin_n,
    input wire logic watchdogTimeout,
    // core side, same clock
    input wire logic sleepExec,
    input wire logic irqWake,
    input wire logic global_irq_enable,
    input wire logic [rcst_pkg::PC_W-1:0] pcPlusOne,
    // configuration
    input wire rcst_pkg::rcst_osc_t oscMode,
    input wire logic powerup_timer_enable,
    input wire logic brownoutEnable,
    // register port
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // core control
    output logic coreRun,
    output logic oscRun,
    output logic pcLoad,
    output logic [rcst_pkg::PC_W-1:0] pcValue,
    output rcst_pkg::rcst_stat_load_t statusLoad,
    output logic watchdogClear,
    output logic timeout_status_bit,
    output logic power_down_flag,
    output logic irq
);
    localparam int CW = $clog2(PWRT_CYCLES + OST_CYCLES + 1);

    initial begin
        if (PWRT_CYCLES < 1 || OST_CYCLES < 1) begin
            $error("start-up counts must be at least one cycle");
        end
    end

    typedef enum logic [1:0] {S_RUN, S_SLEEP, S_PWRT, S_OST} rcst_state_t;
    typedef enum logic [2:0] {C_NONE, C_POR, C_BROWN, C_EXT, C_WDOG, C_WWAKE,
        C_IWAKE} rcst_cause_t;

    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] syncPrev;
    rcst_state_t state;
    rcst_state_t next_state;
    rcst_cause_t cause;
    logic ostAfter;
    logic next_ostAfter;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [1:0] power_status_reg;
    logic [rcst_pkg::EV_N-1:0] evStat;
    logic [rcst_pkg::EV_N-1:0] evMask;
    logic [rcst_pkg::EV_N-1:0] evSet;
    logic porEv;
    logic brownEv;
    logic extEv;
    logic wdogEv;
    logic crystal;

    // pin inputs pass two flops; edges compare the second stage with a third flop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 4'h0;
            syncB <= 4'h0;
            syncPrev <= 4'h0;
        end else begin
            syncA <= {watchdogTimeout, ~external_reset_pin_n, brownReq, porReq};
            syncB <= syncA;
            syncPrev <= syncB;
        end
    end

    // rising edges of the synchronised requests
    assign porEv = syncB[0] & ~syncPrev[0];
    assign brownEv = syncB[1] & ~syncPrev[1] & brownoutEnable;
    assign extEv = syncB[2] & ~syncPrev[2];
    assign wdogEv = syncB[3] & ~syncPrev[3];
    assign crystal = (oscMode != rcst_pkg::OSC_RC);

    // cause priority: power-on, brown-out, pin, watchdog, then wake-ups
    always_comb begin
        cause = C_NONE;
        if (porEv) begin
            cause = C_POR;
        end else if (brownEv) begin
            cause = C_BROWN;
        end else if (extEv) begin
            cause = C_EXT;
        end else if (wdogEv) begin
            cause = (state == S_SLEEP) ? C_WWAKE : C_WDOG;
        end else if (irqWake && state == S_SLEEP) begin
            cause = C_IWAKE;
        end
    end

    // start-up delay selection per cause and oscillator mode
    always_comb begin
        next_state = state;
        next_ostAfter = ostAfter;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        case (cause)
            C_POR: begin
                next_ostAfter = crystal;
                if (!powerup_timer_enable) begin
                    next_state = S_PWRT;
                    next_cnt = CW'(PWRT_CYCLES - 1);
                end else if (crystal) begin
                    next_state = S_OST;
                    next_cnt = CW'(OST_CYCLES - 1);
                end else begin
                    next_state = S_RUN;
                end
            end
            C_BROWN: begin
                next_state = S_PWRT;
                next_ostAfter = crystal;
                next_cnt = CW'(PWRT_CYCLES - 1);
            end
            C_EXT, C_WDOG: begin
                next_state = S_RUN;
            end
            C_WWAKE, C_IWAKE: begin
                next_ostAfter = 1'b0;
                if (crystal) begin
                    next_state = S_OST;
                    next_cnt = CW'(OST_CYCLES - 1);
                end else begin
                    next_state = S_RUN;
                end
            end
            default: begin
                case (state)
                    S_RUN: begin
                        if (sleepExec) begin
                            next_state = S_SLEEP;
                        end
                    end
                    S_PWRT: begin
                        if (cnt == '0) begin
                            next_state = ostAfter ? S_OST : S_RUN;
                            next_cnt = ostAfter ? CW'(OST_CYCLES - 1) : '0;
                        end
                    end
                    S_OST: begin
                        if (cnt == '0) begin
                            next_state = S_RUN;
                        end
                    end
                    default: begin
                        next_state = state;
                    end
                endcase
            end
        endcase
    end

    // sequencer state, counter and run controls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= S_RUN;
            ostAfter <= 1'b0;
            cnt <= '0;
            coreRun <= 1'b1;
            oscRun <= 1'b1;
        end else begin
            state <= next_state;
            ostAfter <= next_ostAfter;
            cnt <= next_cnt;
            coreRun <= (next_state == S_RUN);
            oscRun <= (next_state != S_SLEEP);
        end
    end

    // program counter and status register loads, one-cycle pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pcLoad <= 1'b0;
            pcValue <= rcst_pkg::PC_RESET;
            statusLoad <= '0;
        end else begin
            pcLoad <= (cause != C_NONE);
            statusLoad.valid <= (cause != C_NONE);
            pcValue <= rcst_pkg::PC_RESET;
            statusLoad.mask <= 8'h00;
            statusLoad.value <= 8'h00;
            case (cause)
                C_POR: begin
                    statusLoad.mask <= rcst_pkg::MSK_POR;
                    statusLoad.value <= rcst_pkg::VAL_POR;
                end
                C_BROWN: begin
                    statusLoad.mask <= rcst_pkg::MSK_BROWN;
                    statusLoad.value <= rcst_pkg::VAL_BROWN;
                end
                C_EXT: begin
                    if (state == S_SLEEP) begin
                        statusLoad.mask <= rcst_pkg::MSK_EXTSLP;
                        statusLoad.value <= rcst_pkg::VAL_EXTSLP;
                    end else begin
                        statusLoad.mask <= rcst_pkg::MSK_EXTRUN;
                        statusLoad.value <= rcst_pkg::VAL_EXTRUN;
                    end
                end
                C_WDOG: begin
                    statusLoad.mask <= rcst_pkg::MSK_WDOG;
                    statusLoad.value <= rcst_pkg::VAL_WDOG;
                end
                C_WWAKE: begin
                    pcValue <= pcPlusOne;
                    statusLoad.mask <= rcst_pkg::MSK_WAKE;
                    statusLoad.value <= rcst_pkg::VAL_WWAKE;
                end
                C_IWAKE: begin
                    pcValue <= global_irq_enable ? rcst_pkg::PC_IRQ : pcPlusOne;
                    statusLoad.mask <= rcst_pkg::MSK_WAKE;
                    statusLoad.value <= rcst_pkg::VAL_IWAKE;
                end
                default: begin
                    pcValue <= rcst_pkg::PC_RESET;
                end
            endcase
        end
    end

    // time-out and power-down bits; the load patterns put them at 4 and 3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timeout_status_bit <= 1'b1;
            power_down_flag <= 1'b1;
            watchdogClear <= 1'b0;
        end else begin
            watchdogClear <= (cause == C_NONE) && (state == S_RUN) && sleepExec;
            case (cause)
                C_POR, C_BROWN: begin
                    timeout_status_bit <= 1'b1;
                    power_down_flag <= 1'b1;
                end
                C_WDOG: begin
                    timeout_status_bit <= 1'b0;
                    power_down_flag <= 1'b1;
                end
                C_WWAKE: begin
                    timeout_status_bit <= 1'b0;
                    power_down_flag <= 1'b0;
                end
                C_EXT, C_IWAKE: begin
                    if (state == S_SLEEP) begin
                        timeout_status_bit <= 1'b1;
                        power_down_flag <= 1'b0;
                    end
                end
                default: begin
                    if (state == S_RUN && sleepExec) begin
                        timeout_status_bit <= 1'b1;
                        power_down_flag <= 1'b0;
                    end
                end
            endcase
        end
    end

    // power status flags: hardware clear beats a software write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_status_reg <= 2'h0;
        end else begin
            if (regWr && regAddr == rcst_pkg::ADDR_PWRSTAT) begin
                power_status_reg <= regWdata[1:0];
            end
            if (cause == C_POR) begin
                power_status_reg[rcst_pkg::BIT_POR] <= 1'b0;
            end
            if (brownEv) begin
                power_status_reg[rcst_pkg::BIT_BROWN] <= 1'b0;
            end
        end
    end

    // sticky event bits, write one to clear, a new event wins
    always_comb begin
        evSet = '0;
        evSet[rcst_pkg::EV_BROWN] = (cause == C_BROWN);
        evSet[rcst_pkg::EV_EXT] = (cause == C_EXT);
        evSet[rcst_pkg::EV_WDOG] = (cause == C_WDOG);
        evSet[rcst_pkg::EV_WWAKE] = (cause == C_WWAKE);
        evSet[rcst_pkg::EV_IWAKE] = (cause == C_IWAKE);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evStat <= '0;
            evMask <= '0;
            irq <= 1'b0;
        end else begin
            if (regWr && regAddr == rcst_pkg::ADDR_EVSTAT) begin
                evStat <= (evStat & ~regWdata[rcst_pkg::EV_N-1:0]) | evSet;
            end else begin
                evStat <= evStat | evSet;
            end
            if (regWr && regAddr == rcst_pkg::ADDR_EVMASK) begin
                evMask <= regWdata[rcst_pkg::EV_N-1:0];
            end
            irq <= |(evStat & evMask);
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= 8'h00;
            if (regRd) begin
                case (regAddr)
                    rcst_pkg::ADDR_PWRSTAT: regRdata <= {6'h00, power_status_reg};
                    rcst_pkg::ADDR_EVSTAT: regRdata <= {3'h0, evStat};
                    rcst_pkg::ADDR_EVMASK: regRdata <= {3'h0, evMask};
                    rcst_pkg::ADDR_CORESTAT: regRdata <= {3'h0, timeout_status_bit,
                        power_down_flag, 1'b0, state};
                    default: regRdata <= 8'h00;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_por_flag_clr: assert property (cause == C_POR |=> !power_status_reg[1])
        else $error("power-on flag not cleared");
    a_brown_flag_clr: assert property (brownEv |=> !power_status_reg[0])
        else $error("brown-out flag not cleared");
    a_por_sets_bits: assert property (cause == C_POR |=> timeout_status_bit && power_down_flag)
        else $error("power-on did not set time-out and power-down");
    a_wdog_wake_bits: assert property (cause == C_WWAKE
        |=> !timeout_status_bit && !power_down_flag)
        else $error("watchdog wake-up bits wrong");
    a_ext_run_keep: assert property (cause == C_EXT && state == S_RUN
        |=> $stable(timeout_status_bit) && $stable(power_down_flag))
        else $error("pin reset changed status bits");
    a_reset_pc_zero: assert property ((cause inside {C_POR, C_BROWN, C_EXT, C_WDOG})
        |=> pcLoad && pcValue == 13'h0000)
        else $error("reset did not load zero");
    a_irq_vector: assert property (cause == C_IWAKE && global_irq_enable
        |=> pcValue == 13'h0004)
        else $error("interrupt vector not taken");
    a_sleep_effects: assert property (cause == C_NONE && state == S_RUN && sleepExec
        |=> watchdogClear && timeout_status_bit && !power_down_flag && !oscRun)
        else $error("sleep side effects missing");
    a_por_status: assert property (cause == C_POR
        |=> statusLoad.mask == 8'hF8 && statusLoad.value == 8'h18)
        else $error("power-on status pattern wrong");
    a_wake_ost: assert property (cause == C_WWAKE && crystal |=> state == S_OST ##1
        (state == S_OST && cause == C_NONE) [*3])
        else $error("wake-up skipped oscillator start delay");

    c_power_on: cover property (cause == C_POR ##1 state == S_PWRT);
    c_wdog_wake: cover property (state == S_SLEEP ##1 cause == C_WWAKE);
    c_irq_wake: cover property (state == S_SLEEP && cause == C_IWAKE && global_irq_enable);
    c_irq_out: cover property (irq && evStat[rcst_pkg::EV_BROWN]);
endmodule

/* File: logic/rcst_pkg.sv */
// constants and types for reset-cause tracking and start-up timing
// Contract
// - power status bit 0 is the brown-out flag, cleared by every brown-out reset.
// - with brown-out detection off the brown-out flag has no meaning.
// - power status bit 1 is the power-on flag, cleared only by power-on reset.
// - crystal modes power-up wait 72 ms plus 1024 periods, or 1024 with timer off; the code runs the 72 ms timer only while powerup_timer_enable is low.
// - RC waits 72 ms on timed power-up and brown-out; crystal brown-out 72ms+1024. The code times power-up when powerup_timer_enable is low.
// - power-on reset sets both time-out and power-down bits.
// - flag pairs encode brown-out, watchdog reset and watchdog wake-up causes.
// - pin reset running leaves bits; in sleep or irq wake gives time-out 1, power-down 0.
// - resets load PC 000h; wake-ups go to PC+1, or 0004h for enabled irq.
// - status patterns for power-on, pin reset running and pin reset in sleep.
// - sleep clears watchdog and prescaler, sets time-out, clears power-down, stops osc.
package rcst_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int PWRT_MS = 72;
    localparam int PWRT_CYCLES = PWRT_MS * (CLK_HZ / 1000);
    localparam int OST_CYCLES = 1024;
    localparam int PC_W = 13;
    // register indices on the plain port
    localparam logic [1:0] ADDR_PWRSTAT = 2'h0;
    localparam logic [1:0] ADDR_EVSTAT = 2'h1;
    localparam logic [1:0] ADDR_EVMASK = 2'h2;
    localparam logic [1:0] ADDR_CORESTAT = 2'h3;
    localparam int BIT_BROWN = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_TIMEOUT = 4;
    localparam int BIT_PWRDN = 3;
    // event bits of the sticky status register
    localparam int EV_BROWN = 0;
    localparam int EV_EXT = 1;
    localparam int EV_WDOG = 2;
    localparam int EV_WWAKE = 3;
    localparam int EV_IWAKE = 4;
    localparam int EV_N = 5;
    // status register load patterns: mask of loaded bits, and their values
    localparam logic [7:0] MSK_POR = 8'hF8;
    localparam logic [7:0] VAL_POR = 8'h18;
    localparam logic [7:0] MSK_EXTRUN = 8'hE0;
    localparam logic [7:0] VAL_EXTRUN = 8'h00;
    localparam logic [7:0] MSK_EXTSLP = 8'hF8;
    localparam logic [7:0] VAL_EXTSLP = 8'h10;
    localparam logic [7:0] MSK_WDOG = 8'hF8;
    localparam logic [7:0] VAL_WDOG = 8'h08;
    localparam logic [7:0] MSK_WAKE = 8'h18;
    localparam logic [7:0] VAL_WWAKE = 8'h00;
    localparam logic [7:0] VAL_IWAKE = 8'h10;
    localparam logic [7:0] MSK_BROWN = 8'hF8;
    localparam logic [7:0] VAL_BROWN = 8'h18;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_IRQ = 13'h0004;
    typedef enum logic [1:0] {OSC_SLOW, OSC_XTAL, OSC_FAST, OSC_RC} rcst_osc_t;
    typedef struct packed {
        logic valid;
        logic [7:0] mask;
        logic [7:0] value;
    } rcst_stat_load_t;
endpackage

/* File: sim/testbench.sv */
// self-checking bench for reset-cause tracking and start-up timing
`timescale 1ns/1ps
module testbench;
    // shortened start-up counts keep the run brief
    localparam int PWRT = 20;
    localparam int OST = 8;
    localparam int LIMIT = 20000;
    // clock, reset and cause inputs
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic porReq = 1'b0;
    logic brownReq = 1'b0;
    logic external_reset_pin_n = 1'b1;
    logic watchdogTimeout = 1'b0;
    logic sleepExec = 1'b0;
    logic irqWake = 1'b0;
    logic global_irq_enable = 1'b0;
    logic [12:0] pcPlusOne = 13'h0000;
    rcst_pkg::rcst_osc_t oscMode = rcst_pkg::OSC_XTAL;
    logic powerup_timer_enable = 1'b0;
    logic brownoutEnable = 1'b1;
    // register port
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    // core control outputs
    logic coreRun, oscRun, pcLoad, watchdogClear, timeout_status_bit, power_down_flag, irq;
    logic [12:0] pcValue;
    rcst_pkg::rcst_stat_load_t statusLoad;
    // bench bookkeeping and expected flag state
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic expTo, expPwrDn;
    logic [1:0] expPs;

    rcst_core #(.PWRT_CYCLES(PWRT), .OST_CYCLES(OST)) u_rcst_core (
        .clk, .rst_n, .porReq, .brownReq, .external_reset_pin_n, .watchdogTimeout,
        .sleepExec, .irqWake, .global_irq_enable, .pcPlusOne, .oscMode,
        .powerup_timer_enable, .brownoutEnable, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .coreRun, .oscRun, .pcLoad, .pcValue, .statusLoad, .watchdogClear,
        .timeout_status_bit, .power_down_flag, .irq
    );

    // free-running clock
    always #20 clk = ~clk;

    // hang guard: counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // value comparison, case equality so unknowns fail
    task automatic chkVal(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // start-up delay in cycles, one cycle of slack for the sync stage
    task automatic chkDelay(input int got, input int exp);
        num_checks++;
        if (got < exp - 1 || got > exp + 1) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // register writes and reads, one-cycle strobes
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // kinds: 0 power-on, 1 brown-out, 2 pin run, 3 pin sleep, 4 dog reset, 5 dog wake,
    // 6/7 irq wake
    function automatic logic [16:0] expLoad(input int k);
        case (k)
            0, 1: return {1'b1, 8'hF8, 8'h18};
            2: return {1'b1, 8'hE0, 8'h00};
            3: return {1'b1, 8'hF8, 8'h10};
            4: return {1'b1, 8'hF8, 8'h08};
            5: return {1'b1, 8'h18, 8'h00};
            default: return {1'b1, 8'h18, 8'h10};
        endcase
    endfunction

    function automatic int expDelay(input int k, input rcst_pkg::rcst_osc_t m, input logic pw);
        logic rc;
        rc = (m == rcst_pkg::OSC_RC);
        case (k)
            0: return rc ? (pw ? 0 : PWRT) : (pw ? OST : PWRT + OST);
            1: return rc ? PWRT : PWRT + OST;
            5, 6, 7: return rc ? 0 : OST;
            default: return 0;
        endcase
    endfunction

    function automatic logic [7:0] expEv(input int k);
        case (k)
            1: return 8'h01;
            2, 3: return 8'h02;
            4: return 8'h04;
            5: return 8'h08;
            default: return 8'h10;
        endcase
    endfunction

    // sleep entry from run state
    task automatic goSleep();
        @(posedge clk);
        sleepExec <= 1'b1;
        @(posedge clk);
        sleepExec <= 1'b0;
        #1;
        expTo = 1'b1;
        expPwrDn = 1'b0;
        chkVal({12'h0, oscRun, coreRun, watchdogClear, timeout_status_bit, power_down_flag},
               17'h00006);
    endtask

    // one cause with every visible consequence checked
    task automatic doCause(input int k, input rcst_pkg::rcst_osc_t m, input logic pw,
                           input logic [7:0] msk);
        logic [12:0] nxt;
        logic [12:0] expPc;
        logic [7:0] d;
        int n;
        nxt = 13'($urandom);
        expPc = (k == 6) ? 13'h0004 : ((k == 5 || k == 7) ? nxt : 13'h0000);
        oscMode <= m;
        powerup_timer_enable <= pw;
        wr(rcst_pkg::ADDR_EVMASK, msk);
        if (k == 3 || k >= 5) begin
            goSleep();
        end
        @(posedge clk);
        pcPlusOne <= nxt;
        global_irq_enable <= (k == 6);
        case (k)
            0: porReq <= 1'b1;
            1: brownReq <= 1'b1;
            2, 3: external_reset_pin_n <= 1'b0;
            4, 5: watchdogTimeout <= 1'b1;
            default: irqWake <= 1'b1;
        endcase
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (pcLoad !== 1'b1 && n < 10);
        // cause-dependent flag changes
        if (k <= 1) begin
            expTo = 1'b1;
            expPwrDn = 1'b1;
        end else if (k != 2) begin
            expTo = (k != 4 && k != 5);
            expPwrDn = (k == 4);
        end
        if (k == 0) expPs[1] = 1'b0;
        if (k == 1) expPs[0] = 1'b0;
        chkVal({16'h0, pcLoad}, 17'h00001);
        chkVal({4'h0, pcValue}, {4'h0, expPc});
        chkVal(statusLoad, expLoad(k));
        chkVal({15'h0, timeout_status_bit, power_down_flag},
               {15'h0, expTo, expPwrDn});
        porReq <= 1'b0;
        brownReq <= 1'b0;
        external_reset_pin_n <= 1'b1;
        watchdogTimeout <= 1'b0;
        irqWake <= 1'b0;
        n = 0;
        while (coreRun !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chkDelay(n, expDelay(k, m, pw));
        rd(rcst_pkg::ADDR_CORESTAT, d);
        chkVal({15'h0, d[4:3]}, {15'h0, expTo, expPwrDn});
        rd(rcst_pkg::ADDR_PWRSTAT, d);
        chkVal({9'h0, d}, {15'h0, expPs});
        if (k != 0) begin
            rd(rcst_pkg::ADDR_EVSTAT, d);
            chkVal({9'h0, d}, {9'h0, expEv(k)});
            chkVal({16'h0, irq}, {16'h0, msk != 8'h00});
            if (msk == 8'h00) begin
                wr(rcst_pkg::ADDR_EVMASK, 8'h1F);
                repeat (2) @(posedge clk);
                #1;
                chkVal({16'h0, irq}, 17'h00001);
            end
        end
        // write-one-to-clear drops the interrupt
        wr(rcst_pkg::ADDR_EVSTAT, 8'h1F);
        repeat (2) @(posedge clk);
        #1;
        chkVal({16'h0, irq}, 17'h00000);
        if (k == 0) begin
            wr(rcst_pkg::ADDR_PWRSTAT, 8'h03);
            expPs = 2'h3;
        end
    endtask

    initial begin
        int r;
        logic [7:0] d;
        r = $urandom(9);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        expTo = 1'b1;
        expPwrDn = 1'b1;
        expPs = 2'h0;
        @(posedge clk);
        #1;
        chkVal({12'h0, oscRun, coreRun, watchdogClear, timeout_status_bit, power_down_flag},
               17'h0001B);
        rd(rcst_pkg::ADDR_PWRSTAT, d);
        chkVal({9'h0, d}, 17'h00000);
        r = $urandom;
        wr(rcst_pkg::ADDR_PWRSTAT, r[7:0]);
        expPs = r[1:0];
        rd(rcst_pkg::ADDR_PWRSTAT, d);
        chkVal({9'h0, d}, {15'h0, expPs});
        // power-on across every oscillator mode and timer setting
        doCause(0, rcst_pkg::OSC_XTAL, 1'b0, 8'h1F);
        doCause(0, rcst_pkg::OSC_FAST, 1'b1, 8'h1F);
        doCause(0, rcst_pkg::OSC_SLOW, 1'b0, 8'h1F);
        doCause(0, rcst_pkg::OSC_RC, 1'b0, 8'h1F);
        doCause(0, rcst_pkg::OSC_RC, 1'b1, 8'h1F);
        // each other cause, both delay classes for brown-out and watchdog wake-up; irq wake-up crystal only
        doCause(1, rcst_pkg::OSC_XTAL, 1'b1, 8'h1F);
        doCause(1, rcst_pkg::OSC_RC, 1'b0, 8'h1F);
        doCause(2, rcst_pkg::OSC_XTAL, 1'b0, 8'h1F);
        doCause(3, rcst_pkg::OSC_FAST, 1'b0, 8'h1F);
        doCause(4, rcst_pkg::OSC_XTAL, 1'b0, 8'h1F);
        doCause(5, rcst_pkg::OSC_XTAL, 1'b0, 8'h1F);
        doCause(5, rcst_pkg::OSC_RC, 1'b0, 8'h1F);
        doCause(6, rcst_pkg::OSC_SLOW, 1'b0, 8'h1F);
        doCause(7, rcst_pkg::OSC_XTAL, 1'b0, 8'h1F);
        doCause(2, rcst_pkg::OSC_XTAL, 1'b0, 8'h00);
        // brown-out with detection off: no reset, no event, flags kept
        brownoutEnable <= 1'b0;
        brownReq <= 1'b1;
        d = 8'h00;
        repeat (6) begin
            @(posedge clk);
            #1;
            d = d | {6'h00, ~coreRun, pcLoad};
        end
        brownReq <= 1'b0;
        brownoutEnable <= 1'b1;
        chkVal({9'h0, d}, 17'h00000);
        rd(rcst_pkg::ADDR_EVSTAT, d);
        chkVal({9'h0, d}, 17'h00000);
        rd(rcst_pkg::ADDR_PWRSTAT, d);
        chkVal({9'h0, d}, {15'h0, expPs});
        // random mix of causes, modes and masks
        repeat (14) begin
            doCause(1 + int'($urandom % 7), rcst_pkg::rcst_osc_t'($urandom % 4),
                    1'($urandom), ($urandom % 2) ? 8'h1F : 8'h00);
        end
        end_of_test();
    end
endmodule
